// ---- design/third_port_pkg.sv ----
// constants shared by the third bidirectional port
package third_port_pkg;
	localparam int          PORT_WIDTH       = 8;
	localparam int          ADDR_WIDTH       = 4;
	localparam logic [3:0]  OFS_PIN_DATA     = 4'h0;
	localparam logic [3:0]  OFS_DIRECTION    = 4'h4;
	localparam logic [3:0]  OFS_ANALOG_SEL   = 4'h8;
	localparam logic [3:0]  OFS_MODE_CTRL    = 4'hc;
	localparam logic [7:0]  DIRECTION_RESET  = 8'hff;
	localparam logic [7:0]  ANALOG_RESET     = 8'h00;
	localparam logic [7:0]  LATCH_CLEAR      = 8'h00;
	localparam int          BIT_LP_MODE      = 0;
	localparam logic [1:0]  LP_FORCED_BITS   = 2'h3;
	localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;
	localparam int          SYNC_STAGES      = 2;
endpackage : third_port_pkg

// ---- design/pin_sync.sv ----
// two-flop synchroniser for one port pin
`timescale 1ns/1ps
`default_nettype none
module pin_sync
	import third_port_pkg::*;
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst_n,
	// pin level in, synchronised level out
	input  wire logic pin_async,
	output var  logic pin_synced
);
	logic meta_ff;
	logic sync_ff;

	// first flop is read by the second only
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else begin
			meta_ff <= pin_async;
			sync_ff <= meta_ff;
		end
	end

	assign pin_synced = sync_ff;
endmodule : pin_sync
`default_nettype wire

// ---- design/bidirectional_port_c.sv ----
// eight-pin bidirectional port with direction, latch and pin readback
// What this block does
// - eight pins, own latch and direction bit
// - direction one tri-states the pin driver
// - direction zero drives latch onto pin
// - data read returns sampled pin levels
// - data write updates latch, driven if output
// - masked data writes are read-modify-write of pins
// - bit writes copy other sampled pins in
// - direction still controls drivers for analog
// - analog pins read back as zero
// - low-power crystal mode reads direction[1:0] as one
// - direction bits read/write, reset to ones
// - latch undefined at power-on, read/write; here only written, since data reads return pin levels
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bidirectional_port_c
	import third_port_pkg::*;
(
	// clock, bus reset and power-on reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        por_n,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic [1:0]       avs_response,
	// pin bit-write helper: mask selects bits to take from writedata; an all-zero mask takes all eight
	input  wire logic [7:0]  bit_write_mask,
	// peripheral override per pin
	input  wire logic [7:0]  periph_enable,
	input  wire logic [7:0]  periph_out,
	input  wire logic [7:0]  periph_oe,
	// pins
	input  wire logic [7:0]  third_port_pin_bits_in,
	output logic [7:0]       third_port_pin_bits_out,
	output logic [7:0]       third_port_pin_bits_oe,
	// synchronised pin levels for peripherals
	output logic [7:0]       pin_level
);
	logic [7:0]  latch_ff;
	logic [7:0]  third_port_direction_bits_ff;
	logic [7:0]  analog_sel_ff;
	logic        low_power_crystal_osc_mode_ff;
	logic        ack_ff;
	logic [31:0] rdata_ff;
	logic [7:0]  pin_sync_lvl;

	// synchronise every pin before any logic reads it
	genvar g;
	generate
		for (g = 0; g < PORT_WIDTH; g++) begin : g_sync
			pin_sync u_sync (
				.clk_sys    (clk_sys),
				.rst_n      (rst_n),
				.pin_async  (third_port_pin_bits_in[g]),
				.pin_synced (pin_sync_lvl[g])
			);
		end
	endgenerate

	// digital input path: analog pins read zero
	wire [7:0] pin_read_val = pin_sync_lvl & ~analog_sel_ff;
	assign pin_level = pin_read_val;

	// bus decode; one wait cycle then a one-cycle acknowledge
	wire        req        = avs_read | avs_write;
	wire        hit_data   = (avs_address == OFS_PIN_DATA);
	wire        hit_dir    = (avs_address == OFS_DIRECTION);
	wire        hit_ana    = (avs_address == OFS_ANALOG_SEL);
	wire        hit_mode   = (avs_address == OFS_MODE_CTRL);
	wire        mapped     = hit_data | hit_dir | hit_ana | hit_mode;
	wire        lane0      = avs_byteenable[0];
	wire        wr_take    = avs_write & ~ack_ff & lane0;
	assign avs_waitrequest = req & ~ack_ff;
	assign avs_response    = 2'h0;

	// read-modify-write: unmasked bits come from sampled pins, not the latch
	wire [7:0] mask_eff  = (bit_write_mask == 8'h00) ? 8'hff : bit_write_mask;
	wire [7:0] rmw_value = (avs_writedata[7:0] & mask_eff)
		| (pin_read_val & ~mask_eff);

	// direction readback with low-power crystal override
	wire [7:0] dir_read = low_power_crystal_osc_mode_ff
		? {third_port_direction_bits_ff[7:2], LP_FORCED_BITS}
		: third_port_direction_bits_ff;

	wire [7:0] read_mux = hit_data ? pin_read_val
		: hit_dir  ? dir_read
		: hit_ana  ? analog_sel_ff
		: hit_mode ? {7'h00, low_power_crystal_osc_mode_ff}
		: 8'h00;

	// acknowledge toggles once per request so the master sees one answer
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff   <= 1'b0;
			rdata_ff <= UNMAPPED_READ;
		end else begin
			ack_ff   <= req & ~ack_ff;
			// unmapped reads must return zero, not the previous answer
			rdata_ff <= (avs_read & ~ack_ff)
				? (mapped ? {24'h000000, read_mux} : UNMAPPED_READ)
				: rdata_ff;
		end
	end
	assign avs_readdata = rdata_ff;

	// control registers on the ordinary reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			third_port_direction_bits_ff  <= DIRECTION_RESET;
			analog_sel_ff                 <= ANALOG_RESET;
			low_power_crystal_osc_mode_ff <= 1'b0;
		end else if (wr_take) begin
			if (hit_dir)
				third_port_direction_bits_ff <= avs_writedata[7:0];
			if (hit_ana)
				analog_sel_ff <= avs_writedata[7:0];
			if (hit_mode)
				low_power_crystal_osc_mode_ff <= avs_writedata[BIT_LP_MODE];
		end
	end

	// output latch: only power-on clears it; undefined contents are modelled as zero
	always_ff @(posedge clk_sys or negedge por_n) begin
		if (!por_n)
			latch_ff <= LATCH_CLEAR;
		else if (wr_take && hit_data)
			latch_ff <= rmw_value;
	end

	// pin drivers: direction governs even analog pins; peripherals win
	wire [7:0] port_oe = ~third_port_direction_bits_ff;
	assign third_port_pin_bits_oe  = (periph_enable & periph_oe)
		| (~periph_enable & port_oe);
	assign third_port_pin_bits_out = (periph_enable & periph_out)
		| (~periph_enable & latch_ff);

	// checks
	a_input_tristate: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(third_port_direction_bits_ff == 8'hff && periph_enable == 8'h00)
		|-> third_port_pin_bits_oe == 8'h00)
		else $error("input pin driven");
	a_output_drives: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(periph_enable == 8'h00)
		|-> (third_port_pin_bits_out & third_port_pin_bits_oe)
			== (latch_ff & ~third_port_direction_bits_ff))
		else $error("output pin not showing latch");
	a_read_pins: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && hit_data && !ack_ff)
		|=> avs_readdata[7:0] == $past(pin_sync_lvl & ~analog_sel_ff))
		else $error("data read not pin level");
	a_write_latch: assert property (@(posedge clk_sys) disable iff (!rst_n || !por_n)
		(avs_write && hit_data && !ack_ff && lane0 && bit_write_mask == 8'h00)
		|=> latch_ff == $past(avs_writedata[7:0]))
		else $error("latch missed write");
	a_rmw_others: assert property (@(posedge clk_sys) disable iff (!rst_n || !por_n)
		(avs_write && hit_data && !ack_ff && lane0 && bit_write_mask != 8'h00)
		|=> (latch_ff & ~$past(bit_write_mask))
			== ($past(pin_read_val) & ~$past(bit_write_mask)))
		else $error("bit write lost pin levels");
	a_analog_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(pin_level & analog_sel_ff) == 8'h00)
		else $error("analog pin read nonzero");
	a_lp_dir_ones: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && hit_dir && !ack_ff && low_power_crystal_osc_mode_ff)
		|=> avs_readdata[1:0] == 2'h3)
		else $error("low-power direction bits not one");
	a_periph_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
		((periph_enable & (third_port_pin_bits_oe ^ periph_oe)) == 8'h00)
		&& ((periph_enable & periph_oe & (third_port_pin_bits_out ^ periph_out)) == 8'h00))
		else $error("peripheral override lost");
	a_one_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(req && !avs_waitrequest) |=> ack_ff == 1'b0)
		else $error("double acknowledge");

	// bus timing: one wait state, answer held until the next read
	a_wait_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(req && !ack_ff) |-> avs_waitrequest)
		else $error("first request cycle not stalled");
	a_resp_okay: assert property (@(posedge clk_sys) disable iff (!rst_n)
		avs_response == 2'h0)
		else $error("response code not okay");
	a_read_upper: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && !ack_ff) |=> avs_readdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && !ack_ff && !mapped) |=> avs_readdata == UNMAPPED_READ)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(avs_read && !ack_ff) |=> $stable(avs_readdata))
		else $error("read data changed without a read");

	// direction register: written value lands, otherwise holds
	a_dir_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr_take && hit_dir) |=> third_port_direction_bits_ff == $past(avs_writedata[7:0]))
		else $error("direction write lost");
	a_dir_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(wr_take && hit_dir) |=> $stable(third_port_direction_bits_ff))
		else $error("direction changed without write");
	a_dir_read_plain: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && hit_dir && !ack_ff && !low_power_crystal_osc_mode_ff)
		|=> avs_readdata[7:0] == $past(third_port_direction_bits_ff))
		else $error("direction read mismatch");
	a_lp_dir_upper: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(avs_read && hit_dir && !ack_ff)
		|=> avs_readdata[7:2] == $past(third_port_direction_bits_ff[7:2]))
		else $error("upper direction read mismatch");
	// the forced read-back must never reach the drivers
	a_oe_follows_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(periph_enable == 8'h00) |-> third_port_pin_bits_oe == ~third_port_direction_bits_ff)
		else $error("driver enable not from direction");

	// side registers
	a_analog_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr_take && hit_ana) |=> analog_sel_ff == $past(avs_writedata[7:0]))
		else $error("analog select write lost");
	a_mode_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr_take && hit_mode)
		|=> low_power_crystal_osc_mode_ff == $past(avs_writedata[BIT_LP_MODE]))
		else $error("mode write lost");

	// latch: masked bits from write data, hold otherwise, lane 0 gates all
	a_rmw_masked: assert property (@(posedge clk_sys) disable iff (!rst_n || !por_n)
		(wr_take && hit_data && bit_write_mask != 8'h00)
		|=> (latch_ff & $past(bit_write_mask))
			== ($past(avs_writedata[7:0]) & $past(bit_write_mask)))
		else $error("bit write lost data bit");
	a_latch_hold: assert property (@(posedge clk_sys) disable iff (!por_n)
		!(avs_write && !ack_ff && lane0 && hit_data) |=> $stable(latch_ff))
		else $error("latch changed without write");
	a_lane_off: assert property (@(posedge clk_sys) disable iff (!rst_n || !por_n)
		(avs_write && !ack_ff && !lane0) |=> $stable(latch_ff)
			&& $stable(third_port_direction_bits_ff))
		else $error("write without lane 0 took effect");
endmodule : bidirectional_port_c
`default_nettype wire

// ---- testbench/board_pins.sv ----
// board model resolving each port pin from drivers and board levels
`timescale 1ns/1ps
`default_nettype none
module board_pins (
	// port drivers
	input  wire logic [7:0] drv,
	input  wire logic [7:0] oe,
	// level the board holds on undriven pins
	input  wire logic [7:0] ext,
	// resolved pin levels
	output logic [7:0]      pin
);
	// port wins where it drives; board keeps released pins defined, never floating
	assign pin = (oe & drv) | (~oe & ext);
endmodule : board_pins
`default_nettype wire

// ---- testbench/bidirectional_port_c_bench.sv ----
// register-level bench for the third bidirectional port
`timescale 1ns/1ps
`default_nettype none
module bidirectional_port_c_bench
	import third_port_pkg::*;
;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        por_n = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [3:0]  be = 4'h0;
	logic [7:0]  msk = 8'h00;
	logic [7:0]  pen = 8'h00;
	logic [7:0]  pout = 8'h00;
	logic [7:0]  ppoe = 8'h00;
	logic [7:0]  ext = 8'h53;
	logic [31:0] rdata;
	logic [31:0] q;
	logic        wreq;
	logic [7:0]  po, oe, pin;
	int          fail_count = 0;
	int          checked = 0;
	// 250 MHz
	always #2 clk_sys = ~clk_sys;
	bidirectional_port_c i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n),
		.avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq),
		.avs_response(), .bit_write_mask(msk), .periph_enable(pen), .periph_out(pout),
		.periph_oe(ppoe), .third_port_pin_bits_in(pin), .third_port_pin_bits_out(po),
		.third_port_pin_bits_oe(oe), .pin_level());
	board_pins i_board (.drv(po), .oe(oe), .ext(ext), .pin(pin));
	// one avalon transfer; held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
		input logic [7:0] m, input logic [3:0] e);
		int n = 0;
		@(posedge clk_sys);
		adr <= a;
		rd <= ~w;
		wr <= w;
		wd <= {24'h0, d};
		msk <= m;
		be <= e;
		do begin
			@(posedge clk_sys);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		if (wreq !== 1'b0) fail_count++;
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	// watchdog, far beyond the fewer than a hundred cycles the sequence needs
	initial begin
		repeat (5000) @(posedge clk_sys);
		fail_count++;
		tally_and_finish();
	end
	// main sequence; pin waits cover the two-edge synchroniser
	initial begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		bus(1'b0, OFS_DIRECTION, 8'h00, 8'h00, 4'h1);
		chk({q[23:0], oe}, 32'h0000_ff00);
		bus(1'b1, OFS_DIRECTION, 8'h0f, 8'h00, 4'h1);
		bus(1'b1, OFS_PIN_DATA, 8'ha5, 8'h00, 4'h1);
		chk({16'h0, oe, po & oe}, 32'h0000_f0a0);
		repeat (4) @(posedge clk_sys);
		bus(1'b0, OFS_PIN_DATA, 8'h00, 8'h00, 4'h1);
		chk(q, 32'h0000_00a3);
		// bit write of bit 7 only: the rest come from the pins, not the latch
		bus(1'b1, OFS_PIN_DATA, 8'h00, 8'h80, 4'h1);
		bus(1'b1, OFS_DIRECTION, 8'h00, 8'h00, 4'h1);
		chk({16'h0, oe, po}, 32'h0000_ff23);
		repeat (4) @(posedge clk_sys);
		bus(1'b1, OFS_ANALOG_SEL, 8'hff, 8'h00, 4'h1);
		bus(1'b0, OFS_PIN_DATA, 8'h00, 8'h00, 4'h1);
		chk({q[23:0], oe}, 32'h0000_00ff);
		bus(1'b1, OFS_ANALOG_SEL, 8'h00, 8'h00, 4'h1);
		bus(1'b1, OFS_MODE_CTRL, 8'h01, 8'h00, 4'h1);
		bus(1'b0, OFS_DIRECTION, 8'h00, 8'h00, 4'h1);
		chk({q[23:0], oe}, 32'h0000_03ff);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		@(posedge clk_sys);
		rst_n <= 1'b1;
		chk({16'h0, oe, po}, 32'h0000_0023);
		pen <= 8'h01;
		ppoe <= 8'h01;
		@(posedge clk_sys);
		chk({16'h0, oe, po}, 32'h0000_0122);
		pen <= 8'h00;
		ppoe <= 8'h00;
		// lane 0 off: write acked but ignored
		bus(1'b1, OFS_DIRECTION, 8'h00, 8'h00, 4'h0);
		bus(1'b0, OFS_DIRECTION, 8'h00, 8'h00, 4'h1);
		chk(q, 32'h0000_00ff);
		bus(1'b0, 4'h2, 8'h00, 8'h00, 4'h1);
		chk(q, 32'h0000_0000);
		// analog use the advised way: pin stays an input, board level 53
		bus(1'b1, OFS_ANALOG_SEL, 8'h01, 8'h00, 4'h1);
		bus(1'b0, OFS_PIN_DATA, 8'h00, 8'h00, 4'h1);
		chk(q, 32'h0000_0052);
		tally_and_finish();
	end
endmodule : bidirectional_port_c_bench
`default_nettype wire
